// File: shared/misc_pkg.sv
// Purpose: Shared constants and types for the instruction execution block
// Assumes: 32-bit register port, byte addresses, one word per register
// Notes:   Instruction word layout is carried by misc_instr_s
`default_nettype none

package misc_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_INSTR  = 8'h00;
  localparam logic [7:0] OFF_ACCUM  = 8'h04;
  localparam logic [7:0] OFF_PAGEHI = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_PC     = 8'h10;
  localparam logic [7:0] OFF_STACK  = 8'h14;
  localparam logic [7:0] OFF_WDOG   = 8'h18;
  localparam logic [7:0] OFF_FADDR  = 8'h1c;
  localparam logic [7:0] OFF_FDATA  = 8'h20;
  localparam logic [7:0] OFF_CYCLES = 8'h24;

  // ----------------------------------------------------------------
  // Status register bit positions
  // ----------------------------------------------------------------
  localparam int ST_ZERO_BIT    = 0;
  localparam int ST_TIMEOUT_BIT = 1;
  localparam int ST_PWRDN_BIT   = 2;
  localparam int ST_BUSY_BIT    = 3;
  localparam int ST_SKIP_BIT    = 4;
  localparam int ST_PSA_BIT     = 5;

  // ----------------------------------------------------------------
  // Operation codes
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_NOP    = 4'h0;
  localparam logic [3:0] OP_BTSS   = 4'h1;
  localparam logic [3:0] OP_ICALL  = 4'h2;
  localparam logic [3:0] OP_CLRACC = 4'h3;
  localparam logic [3:0] OP_CLRWD  = 4'h4;
  localparam logic [3:0] OP_CLRREG = 4'h5;
  localparam logic [3:0] OP_COMREG = 4'h6;

  // ----------------------------------------------------------------
  // Sizes, timing and reset values
  // ----------------------------------------------------------------
  localparam int PC_W = 11;
  localparam int SP_W = 3;
  localparam int STACK_DEPTH = 8;
  localparam int FILE_DEPTH = 128;
  localparam logic [1:0] TICK_LAST = 2'h3;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ACCUM_RST = 8'h00;
  localparam logic [7:0] PAGEHI_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 11'h000;
  localparam logic PSA_RST = 1'b1;

  // ----------------------------------------------------------------
  // Instruction word carried from the register port to execution
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] op;
    logic [2:0] bitsel;
    logic       dest;
    logic       rsv;
    logic [6:0] faddr;
  } misc_instr_s;

endpackage : misc_pkg

`default_nettype wire

// File: src/misc_core.sv
// Purpose: Executes bit-test-skip, indirect call, clear and complement operations
// Assumes: Instructions are issued by writes to the instruction register
// Notes:   One instruction cycle per four master clocks, made by a divider
`default_nettype none

module misc_core (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_resetn,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata
);

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_CALL2} misc_state_e;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  misc_state_e state_q;
  misc_pkg::misc_instr_s instr_q;
  logic [1:0] div_q;
  logic [7:0] accumulator_q;
  logic [7:0] page_high_register_q;
  logic [misc_pkg::PC_W-1:0] pc_q;
  logic [misc_pkg::SP_W-1:0] sp_q;
  logic [misc_pkg::PC_W-1:0] stack_q [misc_pkg::STACK_DEPTH];
  logic zero_q;
  logic timeout_status_n_q;
  logic powerdown_status_n_q;
  logic skip_q;
  logic psa_q;
  logic [7:0] watchdog_counter_q;
  logic [7:0] shared_prescaler_q;
  logic [6:0] faddr_q;
  logic [15:0] cycles_q;
  logic [7:0] file_mem [misc_pkg::FILE_DEPTH];
  logic [31:0] rdata_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire tick = (div_q == misc_pkg::TICK_LAST);
  wire busy = (state_q != ST_IDLE);
  wire wr_instr = i_wr && (i_addr == misc_pkg::OFF_INSTR);
  wire wr_accum = i_wr && (i_addr == misc_pkg::OFF_ACCUM);
  wire wr_pagehi = i_wr && (i_addr == misc_pkg::OFF_PAGEHI);
  wire wr_status = i_wr && (i_addr == misc_pkg::OFF_STATUS);
  wire wr_pc = i_wr && (i_addr == misc_pkg::OFF_PC);
  wire wr_faddr = i_wr && (i_addr == misc_pkg::OFF_FADDR);
  wire wr_fdata = i_wr && (i_addr == misc_pkg::OFF_FDATA);
  // Issue requests while busy are dropped; software polls the busy bit
  wire accept = wr_instr && !busy;
  wire do_exec = (state_q == ST_EXEC) && tick;
  wire do_call2 = (state_q == ST_CALL2) && tick;
  // A pending skip turns the freshly issued instruction into a no-op
  wire live = do_exec && !skip_q;
  wire is_btss = live && (instr_q.op == misc_pkg::OP_BTSS);
  wire is_call = live && (instr_q.op == misc_pkg::OP_ICALL);
  wire is_clear_accum = live && (instr_q.op == misc_pkg::OP_CLRACC);
  wire is_clrwd = live && (instr_q.op == misc_pkg::OP_CLRWD);
  wire is_clear_reg = live && (instr_q.op == misc_pkg::OP_CLRREG);
  wire is_compl = live && (instr_q.op == misc_pkg::OP_COMREG);

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  wire [7:0] fr_val = file_mem[instr_q.faddr];
  wire bit_hit = fr_val[instr_q.bitsel];
  wire [7:0] com_val = ~fr_val;
  wire com_zero = (com_val == misc_pkg::ZERO_BYTE);
  wire [misc_pkg::PC_W-1:0] pc_next = pc_q + 11'h001;
  wire [misc_pkg::PC_W-1:0] call_target = {page_high_register_q[2:0], accumulator_q};
  wire file_wr_exec = is_clear_reg || (is_compl && instr_q.dest);
  wire [7:0] file_wr_val = is_clear_reg ? misc_pkg::ZERO_BYTE : com_val;
  wire wd_carry = (shared_prescaler_q == 8'hff);

  // ----------------------------------------------------------------
  // Instruction clock divider and sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= ST_IDLE;
      instr_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (accept) begin
            instr_q <= misc_pkg::misc_instr_s'(i_wdata[15:0]);
            state_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (is_call) begin
            state_q <= ST_CALL2;
          end else if (do_exec) begin
            state_q <= ST_IDLE;
          end
        end
        ST_CALL2: begin
          if (tick) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Skip flag and cycle count
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      skip_q <= 1'b0;
      cycles_q <= 16'h0000;
    end else begin
      if (is_btss) begin
        skip_q <= bit_hit;
      end else if (do_exec) begin
        skip_q <= 1'b0;
      end
      // The discarded no-op costs a cycle of its own, so a skip totals two
      if (do_exec || do_call2) begin
        cycles_q <= cycles_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Program counter and return stack
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      pc_q <= misc_pkg::PC_RST;
      sp_q <= '0;
    end else begin
      if (do_call2) begin
        pc_q <= call_target;
      end else if (do_exec) begin
        pc_q <= pc_next;
      end else if (wr_pc && !busy) begin
        pc_q <= i_wdata[misc_pkg::PC_W-1:0];
      end
      if (is_call) begin
        sp_q <= sp_q + 3'h1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (is_call) begin
      stack_q[sp_q] <= pc_next;
    end
  end

  // ----------------------------------------------------------------
  // Accumulator, page-high register and flags
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      accumulator_q <= misc_pkg::ACCUM_RST;
      page_high_register_q <= misc_pkg::PAGEHI_RST;
      zero_q <= 1'b0;
      psa_q <= misc_pkg::PSA_RST;
    end else begin
      if (is_clear_accum) begin
        accumulator_q <= misc_pkg::ZERO_BYTE;
      end else if (is_compl && !instr_q.dest) begin
        accumulator_q <= com_val;
      end else if (wr_accum && !busy) begin
        accumulator_q <= i_wdata[7:0];
      end
      if (wr_pagehi) begin
        page_high_register_q <= i_wdata[7:0];
      end
      if (is_clear_accum || is_clear_reg) begin
        zero_q <= 1'b1;
      end else if (is_compl) begin
        zero_q <= com_zero;
      end else if (wr_status) begin
        zero_q <= i_wdata[misc_pkg::ST_ZERO_BIT];
      end
      if (wr_status) begin
        psa_q <= i_wdata[misc_pkg::ST_PSA_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Watchdog counter, prescaler and reset status bits
  // ----------------------------------------------------------------
  // When the prescaler belongs to the timer side it is frozen here
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      watchdog_counter_q <= 8'h00;
      shared_prescaler_q <= 8'h00;
      timeout_status_n_q <= 1'b1;
      powerdown_status_n_q <= 1'b1;
    end else begin
      if (is_clrwd) begin
        watchdog_counter_q <= 8'h00;
      end else if (tick && (!psa_q || wd_carry)) begin
        watchdog_counter_q <= watchdog_counter_q + 8'h01;
      end
      if (is_clrwd && psa_q) begin
        shared_prescaler_q <= 8'h00;
      end else if (tick && psa_q) begin
        shared_prescaler_q <= shared_prescaler_q + 8'h01;
      end
      if (is_clrwd) begin
        timeout_status_n_q <= 1'b1;
        powerdown_status_n_q <= 1'b1;
      end else if (wr_status) begin
        timeout_status_n_q <= i_wdata[misc_pkg::ST_TIMEOUT_BIT];
        powerdown_status_n_q <= i_wdata[misc_pkg::ST_PWRDN_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // File registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      faddr_q <= 7'h00;
    end else if (wr_faddr) begin
      faddr_q <= i_wdata[6:0];
    end
  end

  // Execution owns the write port; a bus write in the same cycle is lost
  always_ff @(posedge i_mclk) begin
    if (file_wr_exec) begin
      file_mem[instr_q.faddr] <= file_wr_val;
    end else if (wr_fdata) begin
      file_mem[faddr_q] <= i_wdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  wire [7:0] status_val = {2'h0, psa_q, skip_q, busy, powerdown_status_n_q, timeout_status_n_q, zero_q};
  wire [misc_pkg::SP_W-1:0] sp_top = sp_q - 3'h1;
  wire [31:0] rd_mux =
    (i_addr == misc_pkg::OFF_INSTR)  ? {16'h0000, instr_q} :
    (i_addr == misc_pkg::OFF_ACCUM)  ? {24'h000000, accumulator_q} :
    (i_addr == misc_pkg::OFF_PAGEHI) ? {24'h000000, page_high_register_q} :
    (i_addr == misc_pkg::OFF_STATUS) ? {24'h000000, status_val} :
    (i_addr == misc_pkg::OFF_PC)     ? {21'h0, pc_q} :
    (i_addr == misc_pkg::OFF_STACK)  ? {13'h0, stack_q[sp_top], 5'h00, sp_q} :
    (i_addr == misc_pkg::OFF_WDOG)   ? {16'h0000, shared_prescaler_q, watchdog_counter_q} :
    (i_addr == misc_pkg::OFF_FADDR)  ? {25'h0, faddr_q} :
    (i_addr == misc_pkg::OFF_FDATA)  ? {24'h000000, file_mem[faddr_q]} :
    (i_addr == misc_pkg::OFF_CYCLES) ? {16'h0000, cycles_q} :
    32'h00000000;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_q <= 32'h00000000;
    end else if (i_rd) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  assign o_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  a_skip_when_set: assert property (is_btss && bit_hit |=> skip_q)
    else $error("bit test with bit set did not arm skip");
  a_noskip_when_clear: assert property (is_btss && !bit_hit |=> !skip_q)
    else $error("bit test with bit clear armed skip");
  a_skip_discards_op: assert property (do_exec && skip_q |=> $stable(accumulator_q) && !skip_q
    && pc_q == $past(pc_q) + 11'h001)
    else $error("skipped instruction was not a no-op");
  a_call_push_stack: assert property (is_call |=> sp_q == $past(sp_q) + 3'h1
    && stack_q[$past(sp_q)] == $past(pc_q) + 11'h001)
    else $error("call did not push return address");
  a_call_two_cycles: assert property (is_call |=> (state_q == ST_CALL2) [*4] ##1 state_q == ST_IDLE)
    else $error("call did not take two instruction cycles");
  a_call_target_pc: assert property (do_call2 |=> pc_q == {$past(page_high_register_q[2:0]),
    $past(accumulator_q)})
    else $error("call target wrong");
  a_clear_accum_zero: assert property (is_clear_accum |=> accumulator_q == 8'h00 && zero_q)
    else $error("clear accumulator failed");
  a_clrwd_counters: assert property (is_clrwd |=> watchdog_counter_q == 8'h00
    && (shared_prescaler_q == 8'h00) == $past(psa_q || shared_prescaler_q == 8'h00))
    else $error("clear watchdog counters wrong");
  a_clrwd_keep_presc: assert property (is_clrwd && !psa_q |=> $stable(shared_prescaler_q))
    else $error("prescaler changed while assigned away");
  a_clrwd_status_set: assert property (is_clrwd |=> timeout_status_n_q && powerdown_status_n_q
    && state_q == ST_IDLE)
    else $error("clear watchdog status bits wrong");
  a_clear_reg_zero: assert property (is_clear_reg |=> file_mem[$past(instr_q.faddr)] == 8'h00 && zero_q)
    else $error("clear register failed");
  a_compl_to_accum: assert property (is_compl && !instr_q.dest |=> accumulator_q == ~$past(fr_val)
    && zero_q == ($past(fr_val) == 8'hff))
    else $error("complement to accumulator wrong");
  a_compl_to_reg: assert property (is_compl && instr_q.dest |=> file_mem[$past(instr_q.faddr)]
    == ~$past(fr_val) && $stable(accumulator_q))
    else $error("complement to register wrong");
  a_compl_reg_zero: assert property (is_compl && instr_q.dest |=> zero_q == ($past(fr_val) == 8'hff))
    else $error("zero flag after complement to register wrong");
  a_btss_keeps_accum: assert property (is_btss |=> $stable(accumulator_q))
    else $error("bit test changed the accumulator");

endmodule : misc_core

`default_nettype wire

// File: sim/tb.sv
// Purpose: Self-checking bench for the instruction execution block
// Assumes: Register port with read data one cycle after the strobe, busy polled in STATUS
// Notes:   Random operands from seed 9 with corner values mixed in; no inputs tied off
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Stimulus, observation and counters
  // ----------------------------------------------------------------
  logic i_mclk = 1'b0;
  logic i_resetn = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  int errors = 0;
  int num_checks = 0;

  `define CHK(name, exp, got) begin num_checks++; if ((got) !== (exp)) begin errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got); end end

  always #10 i_mclk = ~i_mclk;

  misc_core i_misc_core (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata)
  );

  // ----------------------------------------------------------------
  // Bus tasks and expectations
  // ----------------------------------------------------------------
  function automatic logic zf(input logic [7:0] x);
    return x === 8'h00;
  endfunction : zf

  task automatic finish_test();
    $display("Checks made: %0d, mismatches: %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr

  // Data is taken just after the edge that registers it, its only valid cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask : rd

  task automatic issue(input logic [3:0] op, input logic [2:0] b, input logic d, input logic [6:0] fa);
    misc_pkg::misc_instr_s ins;
    logic [31:0] s;
    ins = {op, b, d, 1'b0, fa};
    wr(misc_pkg::OFF_INSTR, {16'h0, ins});
    for (int n = 0; n < 20; n++) begin
      rd(misc_pkg::OFF_STATUS, s);
      if (s[misc_pkg::ST_BUSY_BIT] === 1'b0) return;
    end
    errors++;
    $display("CHECK FAILED busy expected 0 seen 1");
    finish_test();
  endtask : issue

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin : main
    logic [31:0] r, pc0, cy0, st0, wd0;
    logic [7:0] v, a, ph;
    logic [6:0] fa;
    logic [2:0] b;
    logic [10:0] pw;
    logic dst;
    void'($urandom(9));
    repeat (4) @(posedge i_mclk);
    i_resetn <= 1'b1;
    rd(misc_pkg::OFF_STATUS, r);
    `CHK("status reset", 32'h26, r)
    rd(misc_pkg::OFF_PC, r);
    `CHK("pc reset", 32'h0, r)
    rd(8'hfc, r);
    `CHK("unmapped read", 32'h0, r)
    // Complement to either destination, all-ones and zero operands first
    for (int i = 0; i < 8; i++) begin
      fa = 7'($urandom());
      v = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom());
      a = 8'($urandom());
      dst = i[0];
      wr(misc_pkg::OFF_FADDR, {25'h0, fa});
      wr(misc_pkg::OFF_FDATA, {24'h0, v});
      wr(misc_pkg::OFF_ACCUM, {24'h0, a});
      issue(misc_pkg::OP_COMREG, 3'h0, dst, fa);
      rd(misc_pkg::OFF_ACCUM, r);
      `CHK("accumulator after complement", dst ? a : ~v, r[7:0])
      rd(misc_pkg::OFF_FDATA, r);
      `CHK("reg after complement", dst ? ~v : v, r[7:0])
      rd(misc_pkg::OFF_STATUS, r);
      `CHK("zero after complement", zf(~v), r[misc_pkg::ST_ZERO_BIT])
    end
    // Clear ops force the zero flag even when it starts low
    wr(misc_pkg::OFF_STATUS, 32'h26);
    wr(misc_pkg::OFF_FDATA, {24'h0, 8'($urandom()) | 8'h01});
    issue(misc_pkg::OP_CLRREG, 3'h0, 1'b0, fa);
    rd(misc_pkg::OFF_FDATA, r);
    `CHK("reg after clear", 8'h00, r[7:0])
    rd(misc_pkg::OFF_STATUS, r);
    `CHK("zero after clear reg", 1'b1, r[misc_pkg::ST_ZERO_BIT])
    wr(misc_pkg::OFF_STATUS, 32'h26);
    wr(misc_pkg::OFF_ACCUM, 32'h55);
    issue(misc_pkg::OP_CLRACC, 3'h0, 1'b0, 7'h00);
    rd(misc_pkg::OFF_ACCUM, r);
    `CHK("accumulator after clear", 8'h00, r[7:0])
    rd(misc_pkg::OFF_STATUS, r);
    `CHK("zero after clear acc", 1'b1, r[misc_pkg::ST_ZERO_BIT])
    // Bit test followed by a clear-accumulator that must be dropped when the bit is set
    for (int i = 0; i < 6; i++) begin
      b = 3'($urandom());
      v = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom());
      wr(misc_pkg::OFF_FDATA, {24'h0, v});
      wr(misc_pkg::OFF_ACCUM, 32'h5a);
      rd(misc_pkg::OFF_PC, pc0);
      rd(misc_pkg::OFF_CYCLES, cy0);
      issue(misc_pkg::OP_BTSS, b, 1'b0, fa);
      rd(misc_pkg::OFF_STATUS, r);
      `CHK("skip pending", v[b], r[misc_pkg::ST_SKIP_BIT])
      issue(misc_pkg::OP_CLRACC, 3'h0, 1'b0, 7'h00);
      rd(misc_pkg::OFF_ACCUM, r);
      `CHK("accumulator after skip slot", v[b] ? 8'h5a : 8'h00, r[7:0])
      rd(misc_pkg::OFF_PC, r);
      `CHK("pc after pair", 11'(pc0 + 2), r[10:0])
      rd(misc_pkg::OFF_CYCLES, r);
      `CHK("cycles after pair", 16'(cy0 + 2), r[15:0])
    end
    // Indirect calls: page bits above bit 2 must be ignored
    for (int i = 0; i < 3; i++) begin
      ph = 8'($urandom());
      a = (i == 0) ? 8'hff : 8'($urandom());
      pw = (i == 0) ? 11'h7ff : 11'($urandom());
      wr(misc_pkg::OFF_PAGEHI, {24'h0, ph});
      wr(misc_pkg::OFF_ACCUM, {24'h0, a});
      wr(misc_pkg::OFF_PC, {21'h0, pw});
      rd(misc_pkg::OFF_PC, pc0);
      `CHK("pc write", pw, pc0[10:0])
      rd(misc_pkg::OFF_STACK, st0);
      rd(misc_pkg::OFF_CYCLES, cy0);
      issue(misc_pkg::OP_ICALL, 3'h0, 1'b0, 7'h00);
      rd(misc_pkg::OFF_PC, r);
      `CHK("pc after call", {ph[2:0], a}, r[10:0])
      rd(misc_pkg::OFF_STACK, r);
      `CHK("stack pointer", 3'(st0[2:0] + 1), r[2:0])
      `CHK("return address", 11'(pc0 + 1), r[18:8])
      rd(misc_pkg::OFF_CYCLES, r);
      `CHK("cycles of call", 16'(cy0 + 2), r[15:0])
    end
    // Watchdog clear with prescaler moved away: prescaler must survive
    wr(misc_pkg::OFF_STATUS, 32'h20);
    repeat (100) @(posedge i_mclk);
    wr(misc_pkg::OFF_STATUS, 32'h00);
    repeat (100) @(posedge i_mclk);
    rd(misc_pkg::OFF_CYCLES, cy0);
    rd(misc_pkg::OFF_WDOG, wd0);
    issue(misc_pkg::OP_CLRWD, 3'h0, 1'b0, 7'h00);
    rd(misc_pkg::OFF_WDOG, r);
    `CHK("watchdog cleared", 1'b1, r[7:0] <= 8'h03)
    `CHK("prescaler kept", wd0[15:8], r[15:8])
    rd(misc_pkg::OFF_STATUS, r);
    `CHK("status bits set", 2'b11, {r[misc_pkg::ST_PWRDN_BIT], r[misc_pkg::ST_TIMEOUT_BIT]})
    rd(misc_pkg::OFF_CYCLES, r);
    `CHK("cycles of clear", 16'(cy0 + 1), r[15:0])
    // Watchdog clear with prescaler assigned: both counts return near zero
    wr(misc_pkg::OFF_STATUS, 32'h20);
    repeat (100) @(posedge i_mclk);
    issue(misc_pkg::OP_CLRWD, 3'h0, 1'b0, 7'h00);
    rd(misc_pkg::OFF_WDOG, r);
    `CHK("watchdog cleared", 1'b1, r[7:0] <= 8'h03)
    `CHK("prescaler cleared", 1'b1, r[15:8] <= 8'h03)
    rd(misc_pkg::OFF_STATUS, r);
    `CHK("status bits set", 2'b11, {r[misc_pkg::ST_PWRDN_BIT], r[misc_pkg::ST_TIMEOUT_BIT]})
    finish_test();
  end : main

endmodule : tb

`default_nettype wire
